// file: core/upr_phy_ctrl.sv
// Chosen here: the APB slave port.
`include "upr_map.svh"
// Contract
// R1 - Pulldown bit 18 disables both port pulldowns
// R2 - SE0 auto-resume sets bit 13, zero clears
// R3 - K auto-resume sets bit 12, zero clears
// R4 - Linestate change delayed two-power-field clocks
// R5 - Auto-resume bit lets controller leave suspend
// R6 - Otherwise software polls filtered linestate
// R7 - Config pins follow control bits 6:4
// R8 - Power word holds data and valid
module upr_phy_ctrl (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 resetn_in,
    // APB slave
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    input  wire logic [3:0]           pstrb_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // PHY side
    input  wire logic [1:0]           linestate_in,
    input  wire logic                 suspend_req_in,
    output logic      [2:0]           phy_config_pins_out,
    output logic                      pulldown_dis_out,
    output logic      [1:0]           linestate_filt_out,
    output logic                      suspended_out,
    output logic                      resume_out,
    // Power signalling
    output logic      [7:0]           power_data_out,
    output logic                      power_valid_out
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    upr_pkg::upr_ctrl_s ctrl_reg;
    logic [8:0]         power_reg;
    upr_pkg::upr_st_e   st_reg;
    upr_pkg::upr_ls_e   ls_filt;
    logic               set_se0;
    logic               set_k;
    logic               wr_acc;
    logic               rd_acc;
    logic [31:0]        rd_word;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_acc = psel_in && penable_in && !pwrite_in;

    // ----------------------------------------
    // Linestate filter
    // ----------------------------------------
    upr_ls_filter u_filter (
        .clk_in       (mclk_in),
        .rst_n_in     (rst_n),
        .filt_log2_in (ctrl_reg.filt_log2),
        .ls_raw_in    (upr_pkg::upr_ls_e'(linestate_in)),
        .ls_filt_out  (ls_filt)
    );

    // ----------------------------------------
    // Suspend controller
    // ----------------------------------------
    always_comb begin
        set_se0 = 1'b0;
        set_k   = 1'b0;
        if (st_reg == upr_pkg::UPR_ST_SUSPEND && ctrl_reg.auto_res) begin
            set_se0 = (ls_filt == upr_pkg::UPR_LS_SE0); // [R2]
            set_k   = (ls_filt == upr_pkg::UPR_LS_K);   // [R3]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= upr_pkg::UPR_ST_ACTIVE;
        end else begin
            case (st_reg)
                upr_pkg::UPR_ST_ACTIVE: begin
                    if (suspend_req_in) begin
                        st_reg <= upr_pkg::UPR_ST_SUSPEND;
                    end
                end
                upr_pkg::UPR_ST_SUSPEND: begin
                    if (set_se0 || set_k) begin
                        st_reg <= upr_pkg::UPR_ST_WAKE; // [R5]
                    end else if (!ctrl_reg.auto_res && !suspend_req_in) begin
                        st_reg <= upr_pkg::UPR_ST_ACTIVE; // [R6]
                    end
                end
                upr_pkg::UPR_ST_WAKE: begin
                    st_reg <= upr_pkg::UPR_ST_ACTIVE;
                end
                default: begin
                    st_reg <= upr_pkg::UPR_ST_ACTIVE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Control register writes
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= '0;
        end else begin
            if (wr_acc && hit(paddr_in, `UPR_PHY_CONTROL_OFF)) begin
                if (pstrb_in[2]) begin
                    ctrl_reg.pd_dis <= pwdata_in[`UPR_PD_DIS_BIT];
                end
                if (pstrb_in[1]) begin
                    ctrl_reg.filt_log2 <= pwdata_in[`UPR_FILT_MSB:`UPR_FILT_LSB];
                    if (!pwdata_in[`UPR_SE0_FLAG_BIT]) begin
                        ctrl_reg.se0_flag <= 1'b0;
                    end
                    if (!pwdata_in[`UPR_K_FLAG_BIT]) begin
                        ctrl_reg.k_flag <= 1'b0;
                    end
                end
                if (pstrb_in[0]) begin
                    ctrl_reg.auto_res <= pwdata_in[`UPR_AUTO_RES_BIT];
                    ctrl_reg.conf     <= pwdata_in[`UPR_CONF_MSB:`UPR_CONF_LSB];
                end
            end
            if (set_se0) begin
                ctrl_reg.se0_flag <= 1'b1; // [R2]
            end
            if (set_k) begin
                ctrl_reg.k_flag <= 1'b1; // [R3]
            end
        end
    end

    // ----------------------------------------
    // Power signalling register
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            power_reg <= 9'(`UPR_POWER_SIGNAL_RST);
        end else if (wr_acc && hit(paddr_in, `UPR_POWER_SIGNAL_OFF)) begin
            if (pstrb_in[0]) begin
                power_reg[`UPR_PS_DATA_MSB:0] <= pwdata_in[`UPR_PS_DATA_MSB:0]; // [R8]
            end
            if (pstrb_in[1]) begin
                power_reg[`UPR_PS_VALID_BIT] <= pwdata_in[`UPR_PS_VALID_BIT]; // [R8]
            end
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(paddr_in, `UPR_PHY_CONTROL_OFF)) begin
            rd_word[`UPR_PD_DIS_BIT]              = ctrl_reg.pd_dis;
            rd_word[`UPR_SE0_FLAG_BIT]            = ctrl_reg.se0_flag;
            rd_word[`UPR_K_FLAG_BIT]              = ctrl_reg.k_flag;
            rd_word[`UPR_FILT_MSB:`UPR_FILT_LSB]  = ctrl_reg.filt_log2;
            rd_word[`UPR_AUTO_RES_BIT]            = ctrl_reg.auto_res;
            rd_word[`UPR_CONF_MSB:`UPR_CONF_LSB]  = ctrl_reg.conf;
        end else if (hit(paddr_in, `UPR_POWER_SIGNAL_OFF)) begin
            rd_word[8:0] = power_reg; // [R8]
        end
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in &&
                           !hit(paddr_in, `UPR_PHY_CONTROL_OFF) &&
                           !hit(paddr_in, `UPR_POWER_SIGNAL_OFF);
            if (psel_in && !penable_in && !pwrite_in) begin
                prdata_out <= rd_word;
            end
        end
    end

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            phy_config_pins_out <= 3'h0;
            pulldown_dis_out    <= 1'b0;
            linestate_filt_out  <= 2'h1;
            suspended_out       <= 1'b0;
            resume_out          <= 1'b0;
            power_data_out      <= 8'h00;
            power_valid_out     <= 1'b0;
        end else begin
            phy_config_pins_out <= ctrl_reg.conf;   // [R7]
            pulldown_dis_out    <= ctrl_reg.pd_dis; // [R1]
            linestate_filt_out  <= ls_filt;         // [R4]
            suspended_out       <= (st_reg == upr_pkg::UPR_ST_SUSPEND);
            resume_out          <= (st_reg == upr_pkg::UPR_ST_WAKE); // [R5]
            power_data_out      <= power_reg[7:0];
            power_valid_out     <= power_reg[8];
        end
    end
endmodule

// file: core/upr_map.svh
`ifndef UPR_MAP_SVH
`define UPR_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UPR_POWER_SIGNAL_OFF 12'h03c
`define UPR_PHY_CONTROL_OFF  12'h040
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UPR_PD_DIS_BIT      18
`define UPR_SE0_FLAG_BIT    13
`define UPR_K_FLAG_BIT      12
`define UPR_FILT_LSB        8
`define UPR_FILT_MSB        11
`define UPR_AUTO_RES_BIT    7
`define UPR_CONF_LSB        4
`define UPR_CONF_MSB        6
`define UPR_PS_VALID_BIT    8
`define UPR_PS_DATA_MSB     7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define UPR_POWER_SIGNAL_RST 32'h0000_0000
`define UPR_PHY_CONTROL_RST  32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define UPR_FILT_CNT_W      16
`define UPR_SE0_RESET_NS    2500
`define UPR_CLK_NS          100
`define UPR_SE0_RESET_CYC   ((`UPR_SE0_RESET_NS + `UPR_CLK_NS - 1) / `UPR_CLK_NS)
`endif

// file: core/upr_pkg.sv
package upr_pkg;
    // ----------------------------------------
    // Line states
    // ----------------------------------------
    typedef enum logic [1:0] {
        UPR_LS_SE0 = 2'b00,
        UPR_LS_J   = 2'b01,
        UPR_LS_K   = 2'b10,
        UPR_LS_SE1 = 2'b11
    } upr_ls_e;

    // ----------------------------------------
    // Suspend controller states
    // ----------------------------------------
    typedef enum logic [1:0] {
        UPR_ST_ACTIVE  = 2'b00,
        UPR_ST_SUSPEND = 2'b01,
        UPR_ST_WAKE    = 2'b10
    } upr_st_e;

    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    typedef struct packed {
        logic       pd_dis;
        logic       se0_flag;
        logic       k_flag;
        logic [3:0] filt_log2;
        logic       auto_res;
        logic [2:0] conf;
    } upr_ctrl_s;
endpackage

// file: core/upr_ls_filter.sv
`include "upr_map.svh"
module upr_ls_filter (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // Control
    input  wire logic [3:0]           filt_log2_in,
    // Line state
    input  wire upr_pkg::upr_ls_e     ls_raw_in,
    output upr_pkg::upr_ls_e          ls_filt_out
);
    logic [`UPR_FILT_CNT_W-1:0] cnt_reg;
    upr_pkg::upr_ls_e           cand_reg;
    logic [`UPR_FILT_CNT_W-1:0] limit;

    assign limit = `UPR_FILT_CNT_W'(1) << filt_log2_in;

    // ----------------------------------------
    // Stability counter
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg     <= '0;
            cand_reg    <= upr_pkg::UPR_LS_J;
            ls_filt_out <= upr_pkg::UPR_LS_J;
        end else if (ls_raw_in != cand_reg) begin
            cand_reg <= ls_raw_in;
            cnt_reg  <= `UPR_FILT_CNT_W'(1);
        end else if (cand_reg != ls_filt_out) begin
            if (cnt_reg >= limit) begin
                ls_filt_out <= cand_reg; // [R4]
            end else begin
                cnt_reg <= cnt_reg + `UPR_FILT_CNT_W'(1);
            end
        end
    end
endmodule

// file: verification/upr_phy_model.sv
module upr_phy_model (
    // Clock
    input  wire logic        clk_in,
    // Raw line state
    output upr_pkg::upr_ls_e ls_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Far side line driver
    // ----
    initial ls_out = upr_pkg::UPR_LS_J;
    task automatic drive(input upr_pkg::upr_ls_e v, input int n);
        ls_out <= v;
        repeat (n) @(posedge clk_in);
    endtask
endmodule

// file: verification/upr_phy_ctrl_chk.sv
module upr_phy_ctrl_chk (
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        resetn_in,
    // APB
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // PHY side
    input wire logic [1:0]  linestate_in,
    input wire logic [2:0]  phy_config_pins_out,
    input wire logic        pulldown_dis_out,
    input wire logic [1:0]  linestate_filt_out,
    input wire logic        resume_out,
    input wire logic [7:0]  power_data_out,
    input wire logic        power_valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic wr;
    assign wr = psel_in & penable_in & pready_out & pwrite_in & !pslverr_out;
    a_conf_follow: assert property (wr && paddr_in == 12'h040 && pstrb_in[0]
        |-> ##2 phy_config_pins_out == $past(pwdata_in[6:4], 2)) else $error("conf pins");
    a_pd_follow: assert property (wr && paddr_in == 12'h040 && pstrb_in[2]
        |-> ##2 pulldown_dis_out == $past(pwdata_in[18], 2)) else $error("pulldown");
    a_pw_data: assert property (wr && paddr_in == 12'h03c && pstrb_in[0]
        |-> ##2 power_data_out == $past(pwdata_in[7:0], 2)) else $error("power data");
    a_pw_valid: assert property (wr && paddr_in == 12'h03c && pstrb_in[1]
        |-> ##2 power_valid_out == $past(pwdata_in[8], 2)) else $error("power valid");
    a_err_map: assert property (pready_out |-> pslverr_out ==
        (paddr_in != 12'h03c && paddr_in != 12'h040)) else $error("slave error");
    a_res_pulse: assert property ($rose(resume_out) |=> !resume_out)
        else $error("resume width");
    a_filt_hold: assert property ($changed(linestate_filt_out)
        |-> linestate_filt_out == $past(linestate_in)) else $error("filter");
    a_res_cause: assert property ($rose(resume_out) |-> linestate_filt_out != 2'h1)
        else $error("resume cause");
endmodule

bind upr_phy_ctrl upr_phy_ctrl_chk u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .linestate_in(linestate_in),
    .phy_config_pins_out(phy_config_pins_out), .pulldown_dis_out(pulldown_dis_out),
    .linestate_filt_out(linestate_filt_out), .resume_out(resume_out),
    .power_data_out(power_data_out), .power_valid_out(power_valid_out));

// file: verification/upr_phy_ctrl_tb.sv
module upr_phy_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
    logic        mclk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        sreq = 1'b0, prdy, perr, pd, susp, res, pv, er;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [3:0]  pst = 4'h0;
    logic [2:0]  conf;
    logic [1:0]  ls, lsf;
    logic [7:0]  pdat;
    int          bad_count = 0, check_count = 0;
    upr_phy_ctrl u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pst),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .linestate_in(ls),
        .suspend_req_in(sreq), .phy_config_pins_out(conf), .pulldown_dis_out(pd),
        .linestate_filt_out(lsf), .suspended_out(susp), .resume_out(res),
        .power_data_out(pdat), .power_valid_out(pv));
    upr_phy_model u_phy (.clk_in(mclk_in), .ls_out(ls));
    initial forever #50 mclk_in = ~mclk_in;
    // ----
    // Tasks
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d; pst <= s;
        @(posedge mclk_in);
        pen <= 1'b1;
        i = 0;
        do begin @(posedge mclk_in); i++; end while (prdy !== 1'b1 && i < 20);
        if (prdy !== 1'b1) begin bad_count++; summarize(); end
        rd = prd;
        er = perr;
    endtask
    task automatic rel;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        apb(0, 12'h03c, 32'h0, 4'h0); `CHK("power reset", 32'h0, rd)
        apb(0, 12'h040, 32'h0, 4'h0); `CHK("ctrl reset", 32'h0, rd)
        apb(1, 12'h03c, 32'hffff_ffff, 4'hf);
        apb(0, 12'h03c, 32'h0, 4'h0); `CHK("power rb", 32'h1ff, rd)
        apb(0, 12'h044, 32'h0, 4'h0); `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        rel();
        `CHK("power pins", 9'h1ff, {pv, pdat})
        $display("registers done");
        for (int k = 0; k < 8; k++) begin
            apb(1, 12'h040, (k[0] ? 32'h0004_0000 : 32'h0) | (32'(k) << 4), 4'hf);
            rel();
            repeat (2) @(posedge mclk_in);
            `CHK("conf pins", 3'(k), conf)
            `CHK("pulldown", k[0], pd)
        end
        apb(1, 12'h040, 32'hffff_ffff, 4'hf);
        apb(0, 12'h040, 32'h0, 4'h0); `CHK("ctrl rb", 32'h0004_0ff0, rd)
        apb(1, 12'h040, 32'h0000_0300, 4'hf);
        rel();
        $display("pins done");
        u_phy.drive(upr_pkg::UPR_LS_K, 4);
        u_phy.drive(upr_pkg::UPR_LS_J, 12); `CHK("glitch", 2'h1, lsf)
        u_phy.drive(upr_pkg::UPR_LS_K, 6); `CHK("early", 2'h1, lsf)
        u_phy.drive(upr_pkg::UPR_LS_K, 6); `CHK("late", 2'h2, lsf)
        u_phy.drive(upr_pkg::UPR_LS_J, 12);
        $display("filter done");
        for (int k = 0; k < 2; k++) begin
            apb(1, 12'h040, 32'h80, 4'hf);
            rel();
            sreq <= 1'b1;
            u_phy.drive(upr_pkg::UPR_LS_J, 4); `CHK("suspend", 1'b1, susp)
            u_phy.drive(k ? upr_pkg::UPR_LS_K : upr_pkg::UPR_LS_SE0, 0);
            for (int i = 0; i < 30 && res !== 1'b1; i++) @(posedge mclk_in);
            `CHK("resume", 1'b1, res)
            sreq <= 1'b0;
            u_phy.drive(upr_pkg::UPR_LS_J, 12);
            apb(0, 12'h040, 32'h0, 4'h0); `CHK("flag", k ? 32'h1080 : 32'h2080, rd)
            apb(1, 12'h040, 32'h80, 4'h2);
            apb(0, 12'h040, 32'h0, 4'h0); `CHK("flag clr", 32'h80, rd)
            rel();
        end
        $display("auto resume done");
        apb(1, 12'h040, 32'h0, 4'hf);
        rel();
        sreq <= 1'b1;
        u_phy.drive(upr_pkg::UPR_LS_J, 4);
        u_phy.drive(upr_pkg::UPR_LS_K, 10); `CHK("stay", 3'h6, {susp, lsf})
        sreq <= 1'b0;
        u_phy.drive(upr_pkg::UPR_LS_J, 12); `CHK("leave", 1'b0, susp)
        $display("polled resume done");
        summarize();
    end
endmodule
